// File: dtcf_top.sv
// Board-cache tag state, victim flagging and coherency command handling.
// Assumes synchronous one-cycle request strobes and a system that takes
// each flagged victim and answers each set-dirty request.
`timescale 1ns/1ps
`include "dtcf_params.svh"

module dtcf_top
  import dtcf_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [`DTCF_REG_AW-1:0] REG_ADDR_I,
  input wire logic [`DTCF_REG_DW-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [`DTCF_REG_DW-1:0] REG_RDATA_O,
  input wire logic CPU_REQ_I,
  input wire dtcf_cpu_op_t CPU_OP_I,
  input wire logic [`DTCF_ADDR_MSB:0] CPU_ADDR_I,
  input wire logic [1:0] CPU_WAY_I,
  input wire logic CPU_FILL_SHARED_I,
  input wire logic CPU_FILL_DIRTY_I,
  output logic CPU_DONE_O,
  output logic BUSY_O,
  output logic SET_DIRTY_REQ_O,
  input wire logic SET_DIRTY_ACK_I,
  input wire logic SYS_CMD_VALID_I,
  input wire dtcf_sys_cmd_t SYS_CMD_I,
  input wire logic [`DTCF_ADDR_MSB:0] SYS_ADDR_I,
  output logic SYS_ACK_O,
  output logic SYS_HIT_O,
  output logic SYS_DIRTY_DATA_O,
  output logic DISPLACED_BLOCK_FLAG_O,
  output logic [1:0] DISPLACED_WAY_SELECT_O,
  input wire logic VICTIM_TAKEN_I,
  output logic BC_READ_STALL_O,
  input wire logic EXTERNAL_LOCK_INDICATOR_I,
  output logic LOCK_FLAG_O,
  output logic INNER_INVAL_O,
  output logic [`DTCF_IDX_W-1:0] INNER_INVAL_IDX_O,
  output logic LINE_SIZE_SELECT_O
);

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_VWAIT, S_SDIRTY} dtcf_state_t;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  dtcf_state_t state_ff;
  dtcf_state_t nxt_state;
  dtcf_cfg_t cfg_ff;
  logic busy_ff;
  logic [`DTCF_REG_DW-1:0] rdata_ff;
  logic req_sys_ff;
  dtcf_sys_cmd_t req_cmd_ff;
  dtcf_cpu_op_t req_op_ff;
  dtcf_tag_t req_tag_ff;
  dtcf_idx_t req_idx_ff;
  logic [1:0] req_way_ff;
  logic req_fshared_ff;
  logic req_fdirty_ff;
  logic cpu_done_ff;
  logic sys_ack_ff;
  logic sys_hit_ff;
  logic sys_dirty_ff;
  logic sdreq_ff;
  logic lock_flag_ff;
  dtcf_tag_t lock_tag_ff;
  dtcf_idx_t lock_idx_ff;
  logic inval_ff;
  dtcf_idx_t inval_idx_ff;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire take_sys = (state_ff == S_IDLE) && SYS_CMD_VALID_I;
  wire take_cpu = (state_ff == S_IDLE) && CPU_REQ_I && !SYS_CMD_VALID_I;
  wire take = take_sys || take_cpu;
  wire [`DTCF_ADDR_MSB:0] in_addr = take_sys ? SYS_ADDR_I : CPU_ADDR_I;
  wire dtcf_idx_t in_idx = cfg_ff.line_size_select ?
    in_addr[`DTCF_IDX64_LSB +: `DTCF_IDX_W] :
    in_addr[`DTCF_IDX32_LSB +: `DTCF_IDX_W];
  wire dtcf_tag_t in_tag = in_addr[`DTCF_TAG_MSB:`DTCF_TAG_LSB];

  dtcf_line_t cur;
  wire exec = (state_ff == S_EXEC);
  wire exec_sys = exec && req_sys_ff;
  wire exec_cpu = exec && !req_sys_ff;
  wire tag_match = cur.valid && (cur.tag == req_tag_ff);
  wire force_hit = !cfg_ff.flush_proto && cfg_ff.bc_present;
  wire sys_hit = force_hit || tag_match;
  wire lock_match = (lock_tag_ff == req_tag_ff) && (lock_idx_ff == req_idx_ff);
  wire sys_kills = (req_cmd_ff == SYS_INVALIDATE) ||
    (req_cmd_ff == SYS_FLUSH) || (req_cmd_ff == SYS_READ_DIRTY_INV) ||
    (req_cmd_ff == SYS_UPDATE) ||
    ((req_cmd_ff == SYS_SET_SHARED) && cfg_ff.flush_proto);
  wire sys_supplies = (req_cmd_ff == SYS_READ) ||
    (req_cmd_ff == SYS_READ_DIRTY) || (req_cmd_ff == SYS_READ_DIRTY_INV) ||
    (req_cmd_ff == SYS_FLUSH);
  wire sys_shares = !cfg_ff.flush_proto &&
    ((req_cmd_ff == SYS_READ) || (req_cmd_ff == SYS_READ_DIRTY) ||
    (req_cmd_ff == SYS_SET_SHARED));
  wire need_victim = cur.valid && cur.dirty && !tag_match;
  wire clean_excl = tag_match && !cur.dirty && !cur.shared;
  wire silent_ok = clean_excl && cfg_ff.silent_dirty;

  // Encoding of valid, shared and dirty follows the line struct.
  dtcf_line_t fill_line;
  assign fill_line.valid = 1'b1;
  assign fill_line.shared = req_fshared_ff && !cfg_ff.flush_proto;
  assign fill_line.dirty = req_fdirty_ff;
  assign fill_line.tag = req_tag_ff;

  dtcf_line_t inval_line;
  assign inval_line = '0;

  logic vic_pending;
  logic [1:0] vic_way;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  logic wr_en;
  dtcf_line_t wr_line;
  logic vic_start;
  logic done_p;
  logic fill_p;
  logic sdreq_set;
  logic lock_set;
  logic lock_clr;

  always_comb begin
    nxt_state = state_ff;
    wr_en = 1'b0;
    wr_line = cur;
    vic_start = 1'b0;
    done_p = 1'b0;
    fill_p = 1'b0;
    sdreq_set = 1'b0;
    lock_set = 1'b0;
    lock_clr = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_state = S_EXEC;
        end
      end
      S_EXEC: begin
        nxt_state = S_IDLE;
        if (req_sys_ff) begin
          if (sys_hit && sys_kills) begin
            wr_en = 1'b1;
            wr_line = inval_line;
            lock_clr = lock_match;
          end else if (sys_hit && sys_shares) begin
            wr_en = 1'b1;
            wr_line.shared = 1'b1;
          end
        end else begin
          case (req_op_ff)
            CPU_FILL: begin
              if (need_victim) begin
                vic_start = 1'b1;
                nxt_state = S_VWAIT;
              end else begin
                wr_en = 1'b1;
                wr_line = fill_line;
                fill_p = 1'b1;
                done_p = 1'b1;
              end
            end
            CPU_WRITE: begin
              if (silent_ok) begin
                wr_en = 1'b1;
                wr_line.dirty = 1'b1;
                done_p = 1'b1;
              end else if (tag_match && !cur.dirty) begin
                sdreq_set = 1'b1;
                nxt_state = S_SDIRTY;
              end else begin
                done_p = 1'b1;
              end
            end
            CPU_LOCK: begin
              lock_set = 1'b1;
              done_p = 1'b1;
            end
            default: begin
              done_p = 1'b1;
            end
          endcase
        end
      end
      S_VWAIT: begin
        if (!vic_pending) begin
          wr_en = 1'b1;
          wr_line = fill_line;
          fill_p = 1'b1;
          done_p = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      S_SDIRTY: begin
        if (SET_DIRTY_ACK_I) begin
          wr_en = 1'b1;
          wr_line.dirty = 1'b1;
          done_p = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // A replaced or invalidated valid line leaves the inner caches too.
  wire inner_kill = wr_en && cur.valid &&
    (!wr_line.valid || (wr_line.tag != cur.tag));
  wire nxt_lock_flag = lock_set ? 1'b1 :
    (lock_clr ? 1'b0 :
    (fill_p ? (lock_flag_ff && EXTERNAL_LOCK_INDICATOR_I) :
    lock_flag_ff));

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  wire ctrl_wr = REG_WR_I && (REG_ADDR_I == `DTCF_REG_CTRL);
  wire [`DTCF_STAT_W-1:0] stat_bits = {busy_ff, sdreq_ff, lock_flag_ff,
    vic_pending};
  wire [`DTCF_REG_DW-1:0] rd_mux =
    (REG_ADDR_I == `DTCF_REG_CTRL) ?
      {{(`DTCF_REG_DW-`DTCF_CTRL_W){1'b0}}, cfg_ff} :
    (REG_ADDR_I == `DTCF_REG_STAT) ?
      {{(`DTCF_REG_DW-`DTCF_STAT_W){1'b0}}, stat_bits} :
    {`DTCF_REG_DW{1'b0}};

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      cfg_ff <= dtcf_cfg_t'(`DTCF_CTRL_RST);
      rdata_ff <= '0;
    end else begin
      if (ctrl_wr) begin
        cfg_ff <= dtcf_cfg_t'(REG_WDATA_I[`DTCF_CTRL_W-1:0]);
      end
      rdata_ff <= REG_RD_I ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------------
  // State and request capture
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_ff <= S_IDLE;
      busy_ff <= 1'b0;
      req_sys_ff <= 1'b0;
      req_cmd_ff <= SYS_READ;
      req_op_ff <= CPU_FILL;
      req_tag_ff <= '0;
      req_idx_ff <= '0;
      req_way_ff <= 2'h0;
      req_fshared_ff <= 1'b0;
      req_fdirty_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != S_IDLE);
      if (take) begin
        req_sys_ff <= take_sys;
        req_cmd_ff <= SYS_CMD_I;
        req_op_ff <= CPU_OP_I;
        req_tag_ff <= in_tag;
        req_idx_ff <= in_idx;
        req_way_ff <= CPU_WAY_I;
        req_fshared_ff <= CPU_FILL_SHARED_I;
        req_fdirty_ff <= CPU_FILL_DIRTY_I;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Answers and lock
  // ----------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      cpu_done_ff <= 1'b0;
      sys_ack_ff <= 1'b0;
      sys_hit_ff <= 1'b0;
      sys_dirty_ff <= 1'b0;
      sdreq_ff <= 1'b0;
      lock_flag_ff <= 1'b0;
      lock_tag_ff <= '0;
      lock_idx_ff <= '0;
      inval_ff <= 1'b0;
      inval_idx_ff <= '0;
    end else begin
      cpu_done_ff <= done_p;
      sys_ack_ff <= exec_sys;
      sys_hit_ff <= exec_sys && sys_hit;
      sys_dirty_ff <= exec_sys && sys_hit && sys_supplies && cur.dirty;
      sdreq_ff <= sdreq_set || (sdreq_ff && !SET_DIRTY_ACK_I);
      lock_flag_ff <= nxt_lock_flag;
      if (lock_set) begin
        lock_tag_ff <= req_tag_ff;
        lock_idx_ff <= req_idx_ff;
      end
      inval_ff <= inner_kill;
      inval_idx_ff <= req_idx_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  dtcf_tag_mem u_tag_mem (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .rd_en_i(take),
    .rd_idx_i(in_idx),
    .rd_line_o(cur),
    .wr_en_i(wr_en),
    .wr_idx_i(req_idx_ff),
    .wr_line_i(wr_line)
  );

  dtcf_victim u_victim (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .start_i(vic_start),
    .way_i(req_way_ff),
    .taken_i(VICTIM_TAKEN_I),
    .pending_o(vic_pending),
    .way_o(vic_way)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA_O = rdata_ff;
  assign CPU_DONE_O = cpu_done_ff;
  assign BUSY_O = busy_ff;
  assign SET_DIRTY_REQ_O = sdreq_ff;
  assign SYS_ACK_O = sys_ack_ff;
  assign SYS_HIT_O = sys_hit_ff;
  assign SYS_DIRTY_DATA_O = sys_dirty_ff;
  assign DISPLACED_BLOCK_FLAG_O = vic_pending;
  assign DISPLACED_WAY_SELECT_O = vic_way;
  assign BC_READ_STALL_O = vic_pending;
  assign LOCK_FLAG_O = lock_flag_ff;
  assign INNER_INVAL_O = inval_ff;
  assign INNER_INVAL_IDX_O = inval_idx_ff;
  assign LINE_SIZE_SELECT_O = cfg_ff.line_size_select;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_sys_ack;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      take_sys |=> ##1 SYS_ACK_O;
  endproperty
  a_sys_ack: assert property (p_sys_ack)
    else $error("System command was not acknowledged two cycles on.");

  property p_flush_miss;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (exec_sys && cfg_ff.flush_proto && !tag_match) |-> !wr_en ##1
      (SYS_ACK_O && !SYS_HIT_O && !SYS_DIRTY_DATA_O);
  endproperty
  a_flush_miss: assert property (p_flush_miss)
    else $error("Flush probe miss changed state or reported a hit.");

  property p_force_hit;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (exec_sys && !cfg_ff.flush_proto && cfg_ff.bc_present) |=> SYS_HIT_O;
  endproperty
  a_force_hit: assert property (p_force_hit)
    else $error("Unprobed command was not treated as a hit.");

  property p_no_shared;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (wr_en && cfg_ff.flush_proto) |-> !wr_line.shared;
  endproperty
  a_no_shared: assert property (p_no_shared)
    else $error("A shared line was written under the flush protocol.");

  property p_upd_inval;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (exec_sys && sys_hit && req_cmd_ff == SYS_UPDATE && cur.shared)
      |-> wr_en && !wr_line.valid;
  endproperty
  a_upd_inval: assert property (p_upd_inval)
    else $error("Update to a shared line did not invalidate it.");

  property p_silent;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (exec_cpu && req_op_ff == CPU_WRITE && clean_excl)
      |=> (SET_DIRTY_REQ_O != $past(cfg_ff.silent_dirty)) &&
      (CPU_DONE_O == $past(cfg_ff.silent_dirty));
  endproperty
  a_silent: assert property (p_silent)
    else $error("Clean-to-dirty path disagrees with the silent setting.");

  property p_disp;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      vic_start |=> DISPLACED_BLOCK_FLAG_O && BC_READ_STALL_O &&
      (DISPLACED_WAY_SELECT_O == $past(req_way_ff));
  endproperty
  a_disp: assert property (p_disp)
    else $error("Dirty eviction not flagged with its way.");

  property p_stall;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (state_ff == S_VWAIT && DISPLACED_BLOCK_FLAG_O) |-> !wr_en && !CPU_DONE_O;
  endproperty
  a_stall: assert property (p_stall)
    else $error("Fill completed before the victim was taken.");

  property p_lock_and;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (fill_p && !EXTERNAL_LOCK_INDICATOR_I) |=> !LOCK_FLAG_O;
  endproperty
  a_lock_and: assert property (p_lock_and)
    else $error("Lock flag survived a fill with the external lock clear.");

  property p_inner;
    @(posedge MCLK_I) disable iff (!RST_N_I)
      (wr_en && cur.valid && !wr_line.valid) |=> INNER_INVAL_O &&
      (INNER_INVAL_IDX_O == $past(req_idx_ff));
  endproperty
  a_inner: assert property (p_inner)
    else $error("Invalidated line was not removed from inner caches.");

endmodule : dtcf_top

// File: dtcf_params.svh
// Constants for the duplicate tag coherency filter: offsets, fields, resets.
// Assumes it is included by every file that names one of these constants.
`ifndef DTCF_PARAMS_SVH
`define DTCF_PARAMS_SVH

// ----------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------
`define DTCF_ADDR_MSB 38
`define DTCF_TAG_MSB 38
`define DTCF_TAG_LSB 20
`define DTCF_IDX_W 8
`define DTCF_IDX64_LSB 6
`define DTCF_IDX32_LSB 5

// ----------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------
`define DTCF_REG_AW 4
`define DTCF_REG_DW 32
`define DTCF_REG_CTRL 4'h0
`define DTCF_REG_STAT 4'h4
`define DTCF_CTRL_W 4
`define DTCF_CTRL_RST 4'h1
`define DTCF_STAT_W 4

`endif

// File: dtcf_pkg.sv
// Types shared by the coherency filter modules.
// Assumes dtcf_params.svh supplies the field widths.
`include "dtcf_params.svh"

package dtcf_pkg;

  typedef logic [`DTCF_TAG_MSB:`DTCF_TAG_LSB] dtcf_tag_t;
  typedef logic [`DTCF_IDX_W-1:0] dtcf_idx_t;

  // One board-cache line state and tag.
  typedef struct packed {
    logic valid;
    logic shared;
    logic dirty;
    dtcf_tag_t tag;
  } dtcf_line_t;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic silent_dirty;
    logic bc_present;
    logic flush_proto;
    logic line_size_select;
  } dtcf_cfg_t;

  typedef enum logic [2:0] {
    SYS_READ = 3'h0,
    SYS_READ_DIRTY = 3'h1,
    SYS_READ_DIRTY_INV = 3'h2,
    SYS_INVALIDATE = 3'h3,
    SYS_FLUSH = 3'h4,
    SYS_SET_SHARED = 3'h5,
    SYS_UPDATE = 3'h6
  } dtcf_sys_cmd_t;

  typedef enum logic [1:0] {
    CPU_FILL = 2'h0,
    CPU_WRITE = 2'h1,
    CPU_LOCK = 2'h2
  } dtcf_cpu_op_t;

endpackage : dtcf_pkg

// File: dtcf_tag_mem.sv
// Tag and state store of the board cache, one entry per line.
// Assumes reads and writes never hit the same entry in one cycle.
`timescale 1ns/1ps
`include "dtcf_params.svh"

module dtcf_tag_mem
  import dtcf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_en_i,
  input wire dtcf_idx_t rd_idx_i,
  output dtcf_line_t rd_line_o,
  input wire logic wr_en_i,
  input wire dtcf_idx_t wr_idx_i,
  input wire dtcf_line_t wr_line_i
);

  logic [(1<<`DTCF_IDX_W)-1:0] valid_ff;
  dtcf_line_t mem_ff [0:(1<<`DTCF_IDX_W)-1];
  dtcf_line_t rd_line_ff;

  // Valid bits reset; the rest of each entry is don't-care while invalid.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      valid_ff <= '0;
    end else if (wr_en_i) begin
      valid_ff[wr_idx_i] <= wr_line_i.valid;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_idx_i] <= wr_line_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_line_ff <= '0;
    end else if (rd_en_i) begin
      rd_line_ff <= mem_ff[rd_idx_i];
      rd_line_ff.valid <= valid_ff[rd_idx_i];
    end
  end

  assign rd_line_o = rd_line_ff;

endmodule : dtcf_tag_mem

// File: dtcf_victim.sv
// Displaced dirty line tracker: flags a victim until the system takes it.
// Assumes start and taken are single-cycle pulses from synchronous logic.
`timescale 1ns/1ps

module dtcf_victim (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [1:0] way_i,
  input wire logic taken_i,
  output logic pending_o,
  output logic [1:0] way_o
);

  logic pending_ff;
  logic [1:0] way_ff;

  // A new victim wins over a take in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pending_ff <= 1'b0;
      way_ff <= 2'h0;
    end else if (start_i) begin
      pending_ff <= 1'b1;
      way_ff <= way_i;
    end else if (taken_i) begin
      pending_ff <= 1'b0;
    end
  end

  assign pending_o = pending_ff;
  assign way_o = way_ff;

  property p_vic_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (pending_ff && !taken_i) |=> pending_ff && $stable(way_ff);
  endproperty
  a_vic_hold: assert property (p_vic_hold)
    else $error("Victim flag dropped before the system took it.");

endmodule : dtcf_victim

// File: dtcf_sys_model.sv
// System-side partner: takes flagged victims and grants set-dirty requests.
// Assumes the block's flag and request are registered levels.
`timescale 1ns/1ps

module dtcf_sys_model #(
  parameter int VDLY = 2,
  parameter int ADLY = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flag_i,
  input wire logic sd_req_i,
  input wire logic [1:0] way_i,
  output logic taken_o,
  output logic sd_ack_o,
  output logic [1:0] mirror_way_o
);
  int vc;
  int ac;

  // Victim entry of the tag mirror, loaded in the cycle the flag is seen.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) mirror_way_o <= 2'h0;
    else if (flag_i) mirror_way_o <= way_i;
  end

  // ----------------------------------------------------------------
  // Victim take and set-dirty grant, each after a fixed wait.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    taken_o <= 1'b0;
    sd_ack_o <= 1'b0;
    if (!rst_n_i || !flag_i) vc <= 0;
    else if (vc == VDLY) begin
      taken_o <= 1'b1;
      vc <= 0;
    end else vc <= vc + 1;
    if (!rst_n_i || !sd_req_i) ac <= 0;
    else if (ac == ADLY) begin
      sd_ack_o <= 1'b1;
      ac <= 0;
    end else ac <= ac + 1;
  end
endmodule : dtcf_sys_model

// File: test_duplicate_tag_coherency_filter.sv
// Self-checking bench for the coherency filter top.
// Assumes the partner model answers victims and set-dirty requests.
`timescale 1ns/1ps

module test_duplicate_tag_coherency_filter
  import dtcf_pkg::*;
;
  typedef struct packed {
    logic [3:0] cfg;
    dtcf_sys_cmd_t cmd;
    logic hit;
  } dtcf_row_t;
  logic clk, rst_n, wr, rd, creq, csh, cdt, sdreq, sdack, sval, sack;
  logic shit, sdd, cdone, busy, vflag, vtaken, stall, xlock, lock;
  logic iinv, lss, saw_v, saw_sd, h, d;
  logic [3:0] ra;
  logic [31:0] wd, rdat, r;
  logic [38:0] cadr, sadr;
  logic [1:0] cway, vsel, vw, mway;
  logic [7:0] iidx;
  dtcf_cpu_op_t cop;
  dtcf_sys_cmd_t scmd;
  int num_errors, cmp_count;
  dtcf_row_t rows [8] = '{'{4'h7, SYS_READ, 1'b0},
    '{4'h7, SYS_FLUSH, 1'b0}, '{4'h7, SYS_INVALIDATE, 1'b0},
    '{4'h7, SYS_SET_SHARED, 1'b0}, '{4'h5, SYS_READ_DIRTY, 1'b1},
    '{4'h5, SYS_READ_DIRTY_INV, 1'b1}, '{4'h5, SYS_UPDATE, 1'b1},
    '{4'h1, SYS_READ, 1'b0}};

  dtcf_top dut (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(ra),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat),
    .CPU_REQ_I(creq), .CPU_OP_I(cop), .CPU_ADDR_I(cadr), .CPU_WAY_I(cway),
    .CPU_FILL_SHARED_I(csh), .CPU_FILL_DIRTY_I(cdt), .CPU_DONE_O(cdone),
    .BUSY_O(busy), .SET_DIRTY_REQ_O(sdreq), .SET_DIRTY_ACK_I(sdack),
    .SYS_CMD_VALID_I(sval), .SYS_CMD_I(scmd), .SYS_ADDR_I(sadr),
    .SYS_ACK_O(sack), .SYS_HIT_O(shit), .SYS_DIRTY_DATA_O(sdd),
    .DISPLACED_BLOCK_FLAG_O(vflag), .DISPLACED_WAY_SELECT_O(vsel),
    .VICTIM_TAKEN_I(vtaken), .BC_READ_STALL_O(stall),
    .EXTERNAL_LOCK_INDICATOR_I(xlock), .LOCK_FLAG_O(lock),
    .INNER_INVAL_O(iinv), .INNER_INVAL_IDX_O(iidx),
    .LINE_SIZE_SELECT_O(lss));
  dtcf_sys_model sysm (.clk_i(clk), .rst_n_i(rst_n), .flag_i(vflag),
    .sd_req_i(sdreq), .way_i(vsel), .taken_o(vtaken), .sd_ack_o(sdack),
    .mirror_way_o(mway));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic waitfor(input bit s);
    int n;
    n = 0;
    while (!(s ? sack === 1'b1 : cdone === 1'b1)) begin
      @(posedge clk);
      #1;
      check("stall", vflag, stall);
      check("busy", s ? !sack : !cdone, busy);
      if (vflag === 1'b1) saw_v = 1'b1;
      if (vflag === 1'b1) vw = vsel;
      if (sdreq === 1'b1) saw_sd = 1'b1;
      n++;
      if (n > 300) begin
        num_errors++;
        $display("BAD wait expected done seen none");
        results();
      end
    end
  endtask : waitfor

  task automatic cpu(input dtcf_cpu_op_t o, input logic [38:0] a,
                     input logic [1:0] w, input logic s, dt);
    @(posedge clk);
    creq <= 1'b1;
    cop <= o;
    cadr <= a;
    cway <= w;
    csh <= s;
    cdt <= dt;
    @(posedge clk);
    creq <= 1'b0;
    waitfor(1'b0);
  endtask : cpu

  task automatic sys(input dtcf_sys_cmd_t c, input logic [38:0] a);
    @(posedge clk);
    sval <= 1'b1;
    scmd <= c;
    sadr <= a;
    @(posedge clk);
    sval <= 1'b0;
    waitfor(1'b1);
    h = shit;
    d = sdd;
  endtask : sys

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    ra <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdat;
  endtask : reg_rd

  function automatic logic [38:0] ad(input int t, input int i);
    return (39'(t) << 20) | (39'(i) << 6);
  endfunction : ad

  // ----------------------------------------------------------------
  // Clock and main sequence.
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rst_n, wr, rd, creq, csh, cdt, sval} = '0;
    {ra, wd, cadr, sadr, cway} = '0;
    cop = CPU_FILL;
    scmd = SYS_READ;
    xlock = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("lss", 1, lss);
    reg_rd(4'h0);
    check("ctrl", 32'h1, r);
    $display("test reset done");
    foreach (rows[i]) begin
      reg_wr(4'h0, 32'(rows[i].cfg));
      sys(rows[i].cmd, 39'h0);
      check("hit", rows[i].hit, h);
    end
    $display("test table done");
    reg_wr(4'h0, 32'h5);
    saw_v = 1'b0;
    cpu(CPU_FILL, ad(1, 3), 2'h1, 1'b0, 1'b1);
    check("victim", 0, saw_v);
    cpu(CPU_FILL, ad(2, 3), 2'h2, 1'b0, 1'b0);
    check("victim", 1, saw_v);
    check("way", 2'h2, vw);
    check("mirror", 2'h2, mway);
    $display("test victim done");
    cpu(CPU_FILL, ad(1, 5), 2'h1, 1'b1, 1'b0);
    reg_wr(4'h0, 32'h7);
    sys(SYS_READ, ad(1, 5));
    check("hit", 1, h);
    reg_wr(4'h0, 32'h5);
    sys(SYS_UPDATE, ad(1, 5));
    check("inval", 1, iinv);
    check("invidx", 8'h05, iidx);
    reg_wr(4'h0, 32'h7);
    sys(SYS_READ, ad(1, 5));
    check("hit", 0, h);
    $display("test update done");
    reg_wr(4'h0, 32'h5);
    saw_sd = 1'b0;
    cpu(CPU_FILL, ad(1, 6), 2'h0, 1'b0, 1'b0);
    cpu(CPU_WRITE, ad(1, 6), 2'h0, 1'b0, 1'b0);
    check("setdirty", 1, saw_sd);
    reg_wr(4'h0, 32'hD);
    saw_sd = 1'b0;
    cpu(CPU_FILL, ad(1, 7), 2'h0, 1'b0, 1'b0);
    cpu(CPU_WRITE, ad(1, 7), 2'h0, 1'b0, 1'b0);
    check("setdirty", 0, saw_sd);
    reg_wr(4'h0, 32'h7);
    sys(SYS_READ, ad(1, 6));
    check("dirty", 1, d);
    sys(SYS_READ, ad(1, 7));
    check("dirty", 1, d);
    $display("test write done");
    cpu(CPU_LOCK, ad(1, 6), 2'h0, 1'b0, 1'b0);
    check("lock", 1, lock);
    @(posedge clk);
    xlock <= 1'b0;
    cpu(CPU_FILL, ad(3, 9), 2'h0, 1'b0, 1'b0);
    check("lock", 0, lock);
    $display("test lock done");
    reg_wr(4'h0, 32'h4);
    reg_rd(4'h0);
    check("ctrl", 32'h4, r);
    check("lss", 0, lss);
    reg_wr(4'h4, 32'hF);
    reg_rd(4'h4);
    check("status", 32'h0, r);
    reg_rd(4'h8);
    check("unmapped", 32'h0, r);
    $display("test registers done");
    cpu(CPU_LOCK, ad(1, 6), 2'h0, 1'b0, 1'b0);
    check("lock", 1, lock);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 check("lss", 1, lss);
    check("lock", 0, lock);
    reg_wr(4'h0, 32'h7);
    sys(SYS_READ, ad(1, 6));
    check("hit", 0, h);
    $display("test mid reset done");
    results();
  end
endmodule : test_duplicate_tag_coherency_filter
